// ===== design/sru_pkg.sv
// Constants, register map and state codes of the setpoint reset/trigger unit.
// Assumes an APB master on pclk and a meter register file outside the block.
package sru_pkg;
  // ------------------------------------------------------------
  // Bus and register map
  // ------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_TARGET = 8'h04;
  localparam logic [7:0] OFF_MODE = 8'h08;
  localparam logic [7:0] OFF_CONST = 8'h0c;
  localparam logic [7:0] OFF_SOURCE = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_LOG_PTR = 8'h18;
  localparam logic [7:0] OFF_LOG_RADDR = 8'h1c;
  localparam logic [7:0] OFF_LOG_RDATA = 8'h20;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CTRL_TRIG_LSB = 0;
  localparam int CTRL_PRINT_BIT = 2;
  localparam int CTRL_LOG_BIT = 3;
  localparam int CTRL_SER_LSB = 4;
  localparam int CTRL_LOGCFG_LSB = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_RELAY_BIT = 1;
  localparam int STAT_WRAP_BIT = 2;
  // ------------------------------------------------------------
  // Encodings and reset values
  // ------------------------------------------------------------
  localparam logic [1:0] TRIG_MAKE = 2'h0;
  localparam logic [1:0] TRIG_BREAK = 2'h1;
  localparam logic [1:0] TRIG_BOTH = 2'h2;
  localparam logic [1:0] TRIG_LEVEL = 2'h3;
  localparam logic [1:0] MODE_CONST = 2'h0;
  localparam logic [1:0] MODE_OVERSHOOT = 2'h1;
  localparam logic [1:0] MODE_ACCUM = 2'h2;
  localparam logic [1:0] MODE_COPY = 2'h3;
  localparam logic [7:0] TARGET_OFF = 8'h00;
  localparam logic [3:0] SER_MODE_PRINT = 4'h3;
  localparam logic [3:0] LOG_CFG_OFF = 4'h0;
  localparam logic signed [31:0] CONST_MIN = -32'sd19999;
  localparam logic signed [31:0] CONST_MAX = 32'sd99999;
  localparam logic [1:0] RST_TRIG = TRIG_MAKE;
  localparam logic [1:0] RST_MODE = MODE_CONST;
  localparam logic [7:0] RST_TARGET = TARGET_OFF;
  localparam logic signed [31:0] RST_CONST = 32'sh0;
  localparam logic [7:0] RST_SOURCE = 8'h01;
  localparam int LOG_BYTES = 65536;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_WRITE = 3'b100
  } sru_state_e;
endpackage : sru_pkg

// ===== design/sru_unit.sv
// Setpoint advanced functions: trigger selection, reset register update,
// print request and data-log sampling, with an APB register slave.
// Assumes relay_on, sample_tick and the values come from logic on pclk,
// and that the meter register file answers rd_addr in the same cycle.

// Notes on behaviour
// R1 - Make: act on relay off-to-on only
// R2 - Break: act on relay on-to-off only
// R3 - Both: act on every relay transition
// R4 - Level: act each sample while relay on
// R5 - Reset target is register 1 to 255
// R6 - Target off disables reset and its settings
// R7 - Constant kind stores the constant
// R8 - Overshoot kind stores input minus setpoint plus constant
// R9 - Accumulate kind adds constant to target
// R10 - Copy kind copies source into target
// R11 - Constant defaults zero, range -19999..99999
// R12 - Constant unavailable in copy kind
// R13 - Copy kind selects a source register
// R14 - Print enable requests print on trigger
// R15 - Print only in serial print mode
// R16 - Log enable records sample on trigger
// R17 - Log only when logging configured on
// R18 - One trigger setting governs all actions
// R19 - Configurer returns control digit to 0..4
// R20 - Log as a loop in 64 KB memory
// R21 - Log from setpoint, button or switch
// R22 - One update per trigger, before next sample
module sru_unit
  import sru_pkg::*;
#(
  parameter int LOG_DEPTH = sru_pkg::LOG_BYTES / 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sru_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic relay_on,
  input wire logic sample_tick,
  input wire logic signed [31:0] input_value,
  input wire logic signed [31:0] setpoint_value,
  input wire logic log_button,
  input wire logic log_switch,
  output logic [7:0] rd_addr,
  input wire logic signed [31:0] rd_data,
  output logic upd_valid,
  output logic [7:0] upd_addr,
  output logic [31:0] upd_data,
  output logic print_req
);
  import sru_pkg::*;

  localparam int LOG_AW = $clog2(LOG_DEPTH);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [1:0] trig;
    logic print_en;
    logic log_en;
    logic [3:0] ser_mode;
    logic [3:0] log_cfg;
    logic [7:0] target;
    logic [1:0] mode;
    logic signed [31:0] rconst;
    logic [7:0] source;
    logic relay_prev;
    sru_state_e state;
    logic [1:0] op_mode;
    logic [7:0] op_target;
    logic signed [31:0] op_in;
    logic signed [31:0] op_sp;
    logic signed [31:0] op_const;
    logic [7:0] rd_addr;
    logic [31:0] upd_data;
    logic upd_valid;
    logic print_req;
    logic log_wr;
    logic [31:0] log_data;
    logic [LOG_AW-1:0] log_ptr;
    logic log_wrap;
    logic [LOG_AW-1:0] log_raddr;
    logic [1:0] btn_sync;
    logic [1:0] sw_sync;
    logic btn_prev;
    logic sw_prev;
    logic [31:0] prdata;
    logic pslverr;
  } sru_state_s;

  sru_state_s st;
  sru_state_s next;
  logic [31:0] log_mem [LOG_DEPTH];

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  function automatic logic sru_fire(input logic [1:0] trig, input logic prev,
                                    input logic now);
    logic hit;
    hit = 1'b0;
    unique case (trig)
      TRIG_MAKE: hit = now & ~prev;
      TRIG_BREAK: hit = ~now & prev;
      TRIG_BOTH: hit = now ^ prev;
      TRIG_LEVEL: hit = now;
    endcase
    return hit;
  endfunction : sru_fire

  function automatic logic [31:0] sru_reset_value(input logic [1:0] mode,
      input logic signed [31:0] in_v, input logic signed [31:0] sp_v,
      input logic signed [31:0] c_v, input logic signed [31:0] d_v);
    logic signed [31:0] r;
    r = c_v;
    unique case (mode)
      MODE_CONST: r = c_v; // see R7
      MODE_OVERSHOOT: r = in_v - sp_v + c_v; // see R8
      MODE_ACCUM: r = d_v + c_v; // see R9
      MODE_COPY: r = d_v; // see R10
    endcase
    return r;
  endfunction : sru_reset_value

  // Out-of-range writes saturate rather than wrap, so a typo cannot flip sign
  function automatic logic signed [31:0] sru_clamp(input logic signed [31:0] v);
    logic signed [31:0] r;
    r = v;
    if (v < CONST_MIN) begin
      r = CONST_MIN;
    end else if (v > CONST_MAX) begin
      r = CONST_MAX;
    end
    return r;
  endfunction : sru_clamp

  // ------------------------------------------------------------
  // Trigger and action decode
  // ------------------------------------------------------------
  logic fire;
  logic log_ok;
  logic btn_edge;
  logic sw_edge;
  logic setup;
  logic wr;

  // One trigger selection drives reset, print and log alike
  assign fire = sample_tick & sru_fire(st.trig, st.relay_prev, relay_on); // see R18
  assign log_ok = (st.log_cfg != LOG_CFG_OFF); // see R17
  assign btn_edge = st.btn_sync[1] & ~st.btn_prev;
  assign sw_edge = st.sw_sync[1] & ~st.sw_prev;
  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite & ~st.pslverr;

  always_comb begin
    next = st;
    next.upd_valid = 1'b0;
    next.print_req = 1'b0;
    next.log_wr = 1'b0;
    next.btn_sync = {st.btn_sync[0], log_button};
    next.sw_sync = {st.sw_sync[0], log_switch};
    next.btn_prev = st.btn_sync[1];
    next.sw_prev = st.sw_sync[1];
    // Edges are judged sample to sample, not clock to clock
    if (sample_tick) begin
      next.relay_prev = relay_on; // see R1 R2 R3 R4
    end
    if (fire && st.print_en && st.ser_mode == SER_MODE_PRINT) begin
      next.print_req = 1'b1; // see R14 R15
    end
    if (log_ok && ((fire && st.log_en) || btn_edge || sw_edge)) begin
      next.log_wr = 1'b1; // see R16 R21
      next.log_data = input_value;
    end
    if (st.log_wr) begin
      next.log_ptr = st.log_ptr + 1'b1; // see R20
      if (&st.log_ptr) begin
        next.log_wrap = 1'b1;
      end
    end
    // Settings are frozen at the trigger so a bus write cannot tear an update
    unique case (st.state)
      ST_IDLE: begin
        if (fire && st.target != TARGET_OFF) begin // see R6
          next.state = ST_READ;
          next.op_mode = st.mode;
          next.op_target = st.target;
          next.op_const = st.rconst;
          next.op_in = input_value;
          next.op_sp = setpoint_value;
          next.rd_addr = (st.mode == MODE_COPY) ? st.source : st.target; // see R10 R13
        end
      end
      ST_READ: begin
        next.upd_data = sru_reset_value(st.op_mode, st.op_in, st.op_sp,
                                        st.op_const, rd_data);
        next.upd_valid = 1'b1; // see R22
        next.state = ST_WRITE;
      end
      ST_WRITE: begin
        next.state = ST_IDLE;
      end
      default: begin
        next.state = ST_IDLE;
      end
    endcase
    // ------------------------------------------------------------
    // APB: read data and error are captured in the setup cycle
    // ------------------------------------------------------------
    if (setup) begin
      next.pslverr = 1'b0;
      next.prdata = 32'h0;
      unique case (paddr)
        OFF_CTRL: begin
          next.prdata[CTRL_TRIG_LSB+:2] = st.trig;
          next.prdata[CTRL_PRINT_BIT] = st.print_en;
          next.prdata[CTRL_LOG_BIT] = st.log_en;
          next.prdata[CTRL_SER_LSB+:4] = st.ser_mode;
          next.prdata[CTRL_LOGCFG_LSB+:4] = st.log_cfg;
        end
        OFF_TARGET: next.prdata[7:0] = st.target;
        OFF_MODE: next.prdata[1:0] = st.mode;
        OFF_CONST: next.prdata = st.rconst;
        OFF_SOURCE: next.prdata[7:0] = st.source;
        OFF_STATUS: begin
          next.prdata[STAT_BUSY_BIT] = (st.state != ST_IDLE);
          next.prdata[STAT_RELAY_BIT] = st.relay_prev;
          next.prdata[STAT_WRAP_BIT] = st.log_wrap;
          next.pslverr = pwrite;
        end
        OFF_LOG_PTR: begin
          next.prdata[LOG_AW-1:0] = st.log_ptr;
          next.pslverr = pwrite;
        end
        OFF_LOG_RADDR: next.prdata[LOG_AW-1:0] = st.log_raddr;
        OFF_LOG_RDATA: begin
          next.prdata = log_mem[st.log_raddr];
          next.pslverr = pwrite;
        end
        default: next.pslverr = 1'b1;
      endcase
    end
    if (wr) begin
      unique case (paddr)
        OFF_CTRL: begin
          next.trig = pwdata[CTRL_TRIG_LSB+:2];
          next.print_en = pwdata[CTRL_PRINT_BIT];
          next.log_en = pwdata[CTRL_LOG_BIT];
          next.ser_mode = pwdata[CTRL_SER_LSB+:4];
          next.log_cfg = pwdata[CTRL_LOGCFG_LSB+:4];
        end
        OFF_TARGET: next.target = pwdata[7:0]; // see R5
        OFF_MODE: begin
          if (st.target != TARGET_OFF) begin // see R6
            next.mode = pwdata[1:0];
          end
        end
        OFF_CONST: begin
          if (st.target != TARGET_OFF && st.mode != MODE_COPY) begin // see R6 R12
            next.rconst = sru_clamp(pwdata); // see R11
          end
        end
        OFF_SOURCE: begin
          if (st.target != TARGET_OFF && st.mode == MODE_COPY) begin // see R13
            next.source = pwdata[7:0];
          end
        end
        OFF_LOG_RADDR: next.log_raddr = pwdata[LOG_AW-1:0];
        default: begin
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.state <= ST_IDLE;
      st.trig <= RST_TRIG;
      st.mode <= RST_MODE;
      st.target <= RST_TARGET;
      st.rconst <= RST_CONST; // see R11
      st.source <= RST_SOURCE;
    end else begin
      st <= next;
    end
  end

  // Loop memory has no reset; only written words are ever meaningful
  always_ff @(posedge pclk) begin
    if (st.log_wr) begin
      log_mem[st.log_ptr] <= st.log_data; // see R20
    end
  end

  assign pready = psel & penable;
  assign prdata = st.prdata;
  assign pslverr = st.pslverr;
  assign rd_addr = st.rd_addr;
  assign upd_valid = st.upd_valid;
  assign upd_addr = st.op_target;
  assign upd_data = st.upd_data;
  assign print_req = st.print_req;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  make_edge_a: assert property (@(posedge pclk) disable iff (!presetn) // see R1
    (st.trig == TRIG_MAKE && fire) |-> (relay_on && !st.relay_prev))
    else $error("make trigger fired without off-to-on");
  break_edge_a: assert property (@(posedge pclk) disable iff (!presetn) // see R2
    (st.trig == TRIG_BREAK && fire) |-> (!relay_on && st.relay_prev))
    else $error("break trigger fired without on-to-off");
  both_edge_a: assert property (@(posedge pclk) disable iff (!presetn) // see R3
    (st.trig == TRIG_BOTH && sample_tick && relay_on != st.relay_prev) |-> fire)
    else $error("both trigger missed a transition");
  level_fire_a: assert property (@(posedge pclk) disable iff (!presetn) // see R4
    (st.trig == TRIG_LEVEL && sample_tick) |-> (fire == relay_on))
    else $error("level trigger disagrees with relay");
  target_off_a: assert property (@(posedge pclk) disable iff (!presetn) // see R6
    (st.state == ST_IDLE && st.target == TARGET_OFF) |=> (st.state == ST_IDLE))
    else $error("reset started with target off");
  accum_value_a: assert property (@(posedge pclk) disable iff (!presetn) // see R9
    (st.state == ST_READ && st.op_mode == MODE_ACCUM)
      |=> (upd_data == $past(rd_data) + $past(st.op_const)))
    else $error("accumulate result wrong");
  update_once_a: assert property (@(posedge pclk) disable iff (!presetn) // see R22
    (st.state == ST_IDLE && fire && st.target != TARGET_OFF)
      |=> !upd_valid ##1 upd_valid ##1 !upd_valid)
    else $error("reset update not single or late");
  const_range_a: assert property (@(posedge pclk) disable iff (!presetn) // see R11
    (st.rconst >= CONST_MIN) && (st.rconst <= CONST_MAX))
    else $error("reset constant out of range");
  copy_lock_a: assert property (@(posedge pclk) disable iff (!presetn) // see R12
    (wr && paddr == OFF_CONST && st.mode == MODE_COPY) |=> $stable(st.rconst))
    else $error("constant changed in copy kind");
  print_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // see R15
    print_req |-> ($past(st.ser_mode) == SER_MODE_PRINT && $past(st.print_en) && $past(fire)))
    else $error("print without print mode");
  log_step_a: assert property (@(posedge pclk) disable iff (!presetn) // see R20
    st.log_wr |=> (st.log_ptr == LOG_AW'($past(st.log_ptr) + 1'b1)))
    else $error("log pointer did not advance");
  const_value_a: assert property (@(posedge pclk) disable iff (!presetn) // see R7
    (st.state == ST_READ && st.op_mode == MODE_CONST) |=> (upd_data == $past(st.op_const)))
    else $error("constant kind result wrong");
  overshoot_value_a: assert property (@(posedge pclk) disable iff (!presetn) // see R8
    (st.state == ST_READ && st.op_mode == MODE_OVERSHOOT)
      |=> (upd_data == $past(st.op_in) - $past(st.op_sp) + $past(st.op_const)))
    else $error("overshoot kind result wrong");
  copy_value_a: assert property (@(posedge pclk) disable iff (!presetn) // see R10
    (st.state == ST_READ && st.op_mode == MODE_COPY) |=> (upd_data == $past(rd_data)))
    else $error("copy kind result wrong");
  copy_source_a: assert property (@(posedge pclk) disable iff (!presetn) // see R13
    (st.state == ST_IDLE && fire && st.target != TARGET_OFF && st.mode == MODE_COPY)
      |=> (rd_addr == $past(st.source)))
    else $error("copy kind read the wrong register");
  upd_target_a: assert property (@(posedge pclk) disable iff (!presetn) // see R5
    upd_valid |-> (upd_addr != TARGET_OFF))
    else $error("update aimed at register zero");
  print_fire_a: assert property (@(posedge pclk) disable iff (!presetn) // see R14
    (fire && st.print_en && st.ser_mode == SER_MODE_PRINT) |=> print_req)
    else $error("enabled print not requested");
  log_fire_a: assert property (@(posedge pclk) disable iff (!presetn) // see R16
    (fire && st.log_en && log_ok) |=> st.log_wr)
    else $error("enabled log sample not taken");
  log_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // see R17
    st.log_wr |-> ($past(st.log_cfg) != LOG_CFG_OFF))
    else $error("log sample taken with logging off");
  log_pin_a: assert property (@(posedge pclk) disable iff (!presetn) // see R21
    (log_ok && (btn_edge || sw_edge)) |=> st.log_wr)
    else $error("button or switch log missed");
endmodule : sru_unit

// ===== verif/sru_regfile_model.sv
// Behavioural meter register file behind the reset update port.
// Assumes the unit reads through rd_addr and expects the answer in the same cycle.
module sru_regfile_model (
  input wire logic pclk,
  input wire logic [7:0] rd_addr,
  output logic signed [31:0] rd_data,
  input wire logic upd_valid,
  input wire logic [7:0] upd_addr,
  input wire logic [31:0] upd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic signed [31:0] mem [256];
  // Non-zero fill so a stale or missed read never looks like a match
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = ~i;
    end
  end
  assign rd_data = mem[rd_addr];
  always @(posedge pclk) begin
    if (upd_valid === 1'b1) begin
      mem[upd_addr] <= upd_data;
    end
  end
endmodule : sru_regfile_model

// ===== verif/tb_top.sv
// Self-checking bench of the setpoint reset/trigger unit.
// Assumes the register file model answers reads; log depth shrunk to 4.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import sru_pkg::*;
  // ------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------
  localparam int D = 4;
  logic pclk, presetn, psel, penable, pwrite, relay_on, sample_tick, log_button, log_switch;
  logic [7:0] paddr, rd_addr, upd_addr;
  logic [31:0] pwdata, prdata, upd_data, q, seed, dv;
  logic pready, pslverr, upd_valid, print_req, e, prev, ef;
  logic signed [31:0] input_value, setpoint_value, rd_data;
  int failures, cmp_count, n_pr, n_up, c, p;
  logic [31:0] up_d, x;
  logic [7:0] up_a;
  logic [1:0] trg;
  logic seq [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
  sru_unit #(.LOG_DEPTH(D)) i_sru_unit (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .relay_on(relay_on), .sample_tick(sample_tick),
    .input_value(input_value), .setpoint_value(setpoint_value), .log_button(log_button),
    .log_switch(log_switch), .rd_addr(rd_addr), .rd_data(rd_data), .upd_valid(upd_valid),
    .upd_addr(upd_addr), .upd_data(upd_data), .print_req(print_req));
  sru_regfile_model i_sru_regfile_model (.pclk(pclk), .rd_addr(rd_addr), .rd_data(rd_data),
    .upd_valid(upd_valid), .upd_addr(upd_addr), .upd_data(upd_data));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk(input string n, input logic [31:0] xp, input logic [31:0] g);
    cmp_count++;
    if (g !== xp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, xp, g);
    end
  endtask : chk
  // One sample period; the bench model predicts whether the trigger fires
  task automatic fire(input logic r);
    @(posedge pclk);
    seed = nxt(seed);
    input_value <= seed;
    relay_on <= r;
    sample_tick <= 1'b1;
    case (trg)
      TRIG_MAKE: ef = !prev && r;
      TRIG_BREAK: ef = prev && !r;
      TRIG_BOTH: ef = prev != r;
      default: ef = r;
    endcase
    prev = r;
    @(posedge pclk);
    sample_tick <= 1'b0;
    n_pr = 0;
    n_up = 0;
    repeat (5) begin
      @(posedge pclk);
      if (print_req === 1'b1) n_pr++;
      if (upd_valid === 1'b1) begin
        n_up++;
        up_a = upd_addr;
        up_d = upd_data;
      end
    end
  endtask : fire
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  // ------------------------------------------------------------
  // Watchdog and main sequence
  // ------------------------------------------------------------
  initial begin
    #3000000;
    failures++;
    end_of_test();
  end
  initial begin
    {presetn, psel, penable, pwrite, relay_on, sample_tick, log_button, log_switch} = '0;
    paddr = '0;
    pwdata = '0;
    failures = 0;
    cmp_count = 0;
    prev = 1'b0;
    seed = 32'd74797;
    input_value = '0;
    setpoint_value = 32'sd1234;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFF_CONST, 0);
    chk("const_reset", 0, q);
    apb(1'b0, 8'h40, 0);
    chk("unmapped_err", 1, e);
    chk("unmapped_data", 0, q);
    $display("test defaults done");
    apb(1'b1, OFF_TARGET, 1);
    for (int t = 0; t < 4; t++) begin
      trg = t[1:0];
      apb(1'b1, OFF_CTRL, t | 32'h34);
      for (int k = 0; k < 5; k++) begin
        fire(seq[k]);
        chk("print_count", ef, n_pr);
        chk("update_count", ef, n_up);
      end
    end
    $display("test trigger done");
    apb(1'b1, OFF_CTRL, {2'h0, TRIG_LEVEL} | 32'h24);
    fire(1'b1);
    chk("print_gated", 0, n_pr);
    $display("test print gate done");
    apb(1'b1, OFF_CTRL, 32'h30 | TRIG_LEVEL);
    apb(1'b1, OFF_TARGET, 255);
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, OFF_MODE, m);
      seed = nxt(seed);
      dv = seed;
      if (m == 3) apb(1'b1, OFF_SOURCE, 9);
      else begin
        c = int'(seed % 32'd100000) - 19999;
        apb(1'b1, OFF_CONST, c);
      end
      i_sru_regfile_model.mem[255] = dv;
      i_sru_regfile_model.mem[9] = ~dv;
      fire(1'b1);
      x = (m == 0) ? c : (m == 1) ? input_value - setpoint_value + c : (m == 2) ? dv + c : ~dv;
      chk("upd_addr", 255, up_a);
      chk("upd_data", x, up_d);
      chk("upd_once", 1, n_up);
      chk("print_off", 0, n_pr);
    end
    $display("test reset kinds done");
    apb(1'b1, OFF_CONST, 123);
    apb(1'b0, OFF_CONST, 0);
    chk("const_copy", c, q);
    apb(1'b1, OFF_MODE, 0);
    apb(1'b1, OFF_CONST, 200000);
    apb(1'b0, OFF_CONST, 0);
    chk("const_high", 99999, q);
    apb(1'b1, OFF_CONST, -30000);
    apb(1'b0, OFF_CONST, 0);
    chk("const_low", -19999, q);
    $display("test constant done");
    apb(1'b1, OFF_TARGET, TARGET_OFF);
    apb(1'b1, OFF_MODE, 1);
    apb(1'b0, OFF_MODE, 0);
    chk("mode_locked", 0, q);
    fire(1'b1);
    chk("target_off", 0, n_up);
    $display("test target off done");
    apb(1'b1, OFF_CTRL, 32'h108 | TRIG_LEVEL);
    apb(1'b0, OFF_LOG_PTR, 0);
    p = 0;
    chk("log_ptr_start", 0, q);
    fire(1'b1);
    x = input_value;
    apb(1'b0, OFF_LOG_PTR, 0);
    chk("log_ptr", (p + 1) % D, q);
    apb(1'b1, OFF_LOG_RADDR, p);
    apb(1'b0, OFF_LOG_RDATA, 0);
    chk("log_data", x, q);
    apb(1'b1, OFF_CTRL, 32'h008 | TRIG_LEVEL);
    fire(1'b1);
    apb(1'b0, OFF_LOG_PTR, 0);
    chk("log_gated", (p + 1) % D, q);
    apb(1'b1, OFF_CTRL, 32'h108 | TRIG_LEVEL);
    @(posedge pclk);
    log_button <= 1'b1;
    log_switch <= 1'b1;
    repeat (6) @(posedge pclk);
    log_button <= 1'b0;
    log_switch <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b0, OFF_LOG_PTR, 0);
    chk("log_button", (p + 2) % D, q);
    log_switch <= 1'b1;
    repeat (6) @(posedge pclk);
    log_switch <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b0, OFF_LOG_PTR, 0);
    chk("log_switch", (p + 3) % D, q);
    repeat (D) fire(1'b1);
    apb(1'b0, OFF_LOG_PTR, 0);
    chk("log_loop", (p + 3) % D, q);
    apb(1'b0, OFF_STATUS, 0);
    chk("log_wrap", 1, q[STAT_WRAP_BIT]);
    $display("test log done");
    end_of_test();
  end
endmodule : tb_top
